// File: design/cdc_clock_distribution.sv
`timescale 1ns/1ps
`default_nettype none

module cdc_clock_distribution
	import cdc_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	// AXI4-Lite write data
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [STRB_W-1:0] wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	// AXI4-Lite write response
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	// AXI4-Lite read data
	output var  logic [DATA_W-1:0] rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	// Straps, memory mode, external 48 MHz
	input  wire logic [POR_W-1:0]  strap_pins,
	input  wire logic              ddr_mode_in,
	input  wire logic              ext_48mhz_pin,
	// Oscillator control
	output var  logic              osc_disable,
	// Memory controller clocks
	output var  logic              mem_clk,
	output var  logic              memory_read_clock,
	output var  logic              memory_double_clock,
	output var  logic              memory_double_clock_inv,
	output var  logic              mem_ipb_clk,
	// PCI clocks
	output var  logic              pci_xlb_clk,
	output var  logic              pci_ipb_clk,
	output var  logic              pci_clk,
	// Peripheral bus clocks
	output var  logic              ipb_free_clk,
	output var  logic              lpc_clk,
	output var  logic              slt_clk,
	output var  logic              dma_clk,
	output var  logic              ata_clk,
	output var  logic              eth_clk,
	output var  logic              usb_clk,
	output var  logic              spi_clk,
	output var  logic              pli_clk,
	output var  logic              irrx_clk,
	output var  logic              irtx_clk,
	output var  logic              serial3_clk,
	output var  logic              serial2_clk,
	output var  logic              serial1_clk,
	output var  logic              irda_clk,
	output var  logic              can_clk,
	output var  logic              can_clk_inv,
	output var  logic              i2c_clk,
	output var  logic              timer_clk,
	output var  logic              timer_wake_clk,
	output var  logic              gpio_clk,
	output var  logic              gpio_wake_clk,
	// 48 MHz tree
	output var  logic              usb_48mhz_clk,
	output var  logic              irda_48mhz_clk
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic              aw_full_reg;
	logic              w_full_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [DATA_W-1:0] w_data_reg;
	logic [STRB_W-1:0] w_strb_reg;
	logic              wr_fire;
	logic [DATA_W-1:0] rd_mux;
	logic [POR_W-1:0]  strap_s1_reg;
	logic [POR_W-1:0]  strap_s2_reg;
	logic [POR_W-1:0]  strap_s3_reg;
	logic              por_valid_reg;
	logic [31:0]       por_reg;
	logic [31:0]       bc_reg;
	logic [31:0]       cfg_reg;
	logic [31:0]       fd_reg;
	logic [31:0]       cke_reg;
	logic [31:0]       osc_reg;
	logic [TAP_W-1:0]  tap_reg;
	logic [2:0]        xlb_idx;
	logic [2:0]        ipb_idx;
	logic [2:0]        pci_idx;
	logic              xlb_src;
	logic              dbl_src;
	logic [3:0]        fd_cnt_reg;
	logic [1:0]        fd_phase_reg;
	logic              fd_out_reg;
	logic [3:0]        fd_ratio;
	logic              ext_s1_reg;
	logic              ext_s2_reg;
	logic              ext_s3_reg;
	logic              ext_lvl_reg;
	logic              ext_sel;
	logic [1:0]        xlb_g;
	logic [IPB_W-1:0]  ipb_g;
	logic [1:0]        t48_g;
	logic              ipb_alt;
	logic              ipb_sel_reg;
	logic              ipb_cur;

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == OFF_ID) || (a == OFF_POR) || (a == OFF_BC) ||
			(a == OFF_CFG) || (a == OFF_FD) || (a == OFF_CKE) ||
			(a == OFF_OSC);
	endfunction : mapped

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [STRB_W-1:0] strb);
		for (int i = 0; i < STRB_W; i++) begin
			if (strb[i]) begin
				old[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		merge = old;
	endfunction : merge

	function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
		wr_hit = wr_fire && (aw_addr_reg == off);
	endfunction : wr_hit

	function automatic logic tap(input logic [TAP_W-1:0] t,
		input logic [2:0] idx);
		tap = t[idx];
	endfunction : tap

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign wr_fire = aw_full_reg && w_full_reg && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
			awready     <= 1'b1;
			wready      <= 1'b1;
			bvalid      <= 1'b0;
			bresp       <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= {awaddr[ADDR_W-1:2], 2'h0};
				awready     <= 1'b0;
			end
			if (wvalid && wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= wdata;
				w_strb_reg <= wstrb;
				wready     <= 1'b0;
			end
			if (wr_fire) begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid      <= 1'b1;
				bresp       <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	always_comb begin
		case ({araddr[ADDR_W-1:2], 2'h0})
			OFF_ID:  rd_mux = ID_VALUE;
			OFF_POR: rd_mux = por_reg;
			OFF_BC:  rd_mux = bc_reg;
			OFF_CFG: begin
				rd_mux          = cfg_reg;
				rd_mux[CFG_DDR] = ddr_mode_in;
				rd_mux[CFG_XLB] = por_reg[POR_PLL0];
			end
			OFF_FD:  rd_mux = fd_reg;
			OFF_CKE: rd_mux = cke_reg;
			OFF_OSC: rd_mux = osc_reg;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_mux;
			rresp   <= mapped({araddr[ADDR_W-1:2], 2'h0}) ? RESP_OKAY
				: RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		strap_s1_reg <= strap_pins;
		strap_s2_reg <= strap_s1_reg;
		strap_s3_reg <= strap_s2_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_valid_reg <= 1'b0;
			por_reg       <= '0;
		end else if (!por_valid_reg && (strap_s2_reg == strap_s3_reg)) begin
			por_valid_reg <= 1'b1;
			por_reg       <= {17'h0, strap_s3_reg} & POR_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (wr_hit(OFF_BC)) begin
			bc_reg <= merge(bc_reg, w_data_reg, w_strb_reg);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= CFG_RESET;
		end else if (wr_hit(OFF_CFG)) begin
			cfg_reg <= merge(cfg_reg, w_data_reg, w_strb_reg) & CFG_RW_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fd_reg <= FD_RESET;
		end else if (wr_hit(OFF_FD)) begin
			fd_reg <= merge(fd_reg, w_data_reg, w_strb_reg) & FD_RW_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cke_reg <= CKE_RESET;
		end else if (wr_hit(OFF_CKE)) begin
			cke_reg <= merge(cke_reg, w_data_reg, w_strb_reg) & CKE_RW_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_reg <= OSC_RESET;
		end else if (wr_hit(OFF_OSC)) begin
			osc_reg <= merge(osc_reg, w_data_reg, w_strb_reg) & OSC_RW_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_disable <= 1'b0;
		end else begin
			osc_disable <= osc_reg[OSC_DIS];
		end
	end

	// ----------------------------------------------------------------
	// VCO taps and bus clock ratios
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tap_reg <= '0;
		end else begin
			tap_reg <= tap_reg + 1'b1;
		end
	end

	assign xlb_idx = TAP_XLB + {2'h0, por_reg[POR_XLB]};
	assign ipb_idx = xlb_idx + {2'h0, cfg_reg[CFG_IPB]};
	assign pci_idx = ipb_idx + {2'h0, cfg_reg[CFG_PCI]};
	assign xlb_src = tap(tap_reg, xlb_idx);
	assign dbl_src = tap(tap_reg, TAP_DBL + {2'h0, por_reg[POR_XLB]});
	assign ipb_alt = tap(tap_reg, xlb_idx + 3'h1);

	// Twin of the bus clock swap so both CAN copies stay complementary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ipb_sel_reg <= 1'b0;
		end else if (!xlb_src && !ipb_alt) begin
			ipb_sel_reg <= cfg_reg[CFG_IPB];
		end
	end

	assign ipb_cur = ipb_sel_reg ? ipb_alt : xlb_src;

	cdc_clock_gate #(.WIDTH(2)) u_xlb (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src_a   (tap(tap_reg, TAP_XLB)),
		.src_b   (tap(tap_reg, TAP_XLB + 3'h1)),
		.sel     (por_reg[POR_XLB]),
		.en      ({cke_reg[CK_PCI], cke_reg[CK_MEM]}),
		.clk_out (xlb_g)
	);

	cdc_clock_gate #(.WIDTH(1)) u_dbl (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src_a   (tap(tap_reg, TAP_DBL)),
		.src_b   (tap(tap_reg, TAP_DBL + 3'h1)),
		.sel     (por_reg[POR_XLB]),
		.en      (cke_reg[CK_MEM]),
		.clk_out (memory_double_clock)
	);

	cdc_clock_gate #(.WIDTH(1)) u_dbl_inv (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src_a   (!tap(tap_reg, TAP_DBL)),
		.src_b   (!tap(tap_reg, TAP_DBL + 3'h1)),
		.sel     (por_reg[POR_XLB]),
		.en      (cke_reg[CK_MEM]),
		.clk_out (memory_double_clock_inv)
	);

	cdc_clock_gate #(.WIDTH(1)) u_rd (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src_a   (xlb_src),
		.src_b   (dbl_src),
		.sel     (ddr_mode_in),
		.en      (cke_reg[CK_MEM]),
		.clk_out (memory_read_clock)
	);

	cdc_clock_gate #(.WIDTH(IPB_W)) u_ipb (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src_a   (xlb_src),
		.src_b   (tap(tap_reg, xlb_idx + 3'h1)),
		.sel     (cfg_reg[CFG_IPB]),
		.en      ({4'hf, cke_reg[CK_PCI], cke_reg[CK_PERIPH_W-1:0]}),
		.clk_out (ipb_g)
	);

	cdc_clock_gate #(.WIDTH(1)) u_can_inv (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src_a   (!ipb_cur),
		.src_b   (!ipb_cur),
		.sel     (1'b0),
		.en      (cke_reg[CK_CAN]),
		.clk_out (can_clk_inv)
	);

	cdc_clock_gate #(.WIDTH(1)) u_pci (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src_a   (tap(tap_reg, ipb_idx)),
		.src_b   (tap(tap_reg, ipb_idx + 3'h1)),
		.sel     (cfg_reg[CFG_PCI]),
		.en      (cke_reg[CK_PCI]),
		.clk_out (pci_clk)
	);

	assign mem_clk        = xlb_g[0];
	assign pci_xlb_clk    = xlb_g[1];
	assign pci_ipb_clk    = ipb_g[IPB_PCI];
	assign ipb_free_clk   = ipb_g[IPB_FREE];
	assign mem_ipb_clk    = ipb_g[IPB_MEM];
	assign timer_wake_clk = ipb_g[IPB_TWAKE];
	assign gpio_wake_clk  = ipb_g[IPB_GWAKE];
	assign lpc_clk        = ipb_g[CK_LPC];
	assign slt_clk        = ipb_g[CK_SLT];
	assign dma_clk        = ipb_g[CK_DMA];
	assign ata_clk        = ipb_g[CK_ATA];
	assign eth_clk        = ipb_g[CK_ETH];
	assign usb_clk        = ipb_g[CK_USB];
	assign spi_clk        = ipb_g[CK_SPI];
	assign pli_clk        = ipb_g[CK_PLI];
	assign irrx_clk       = ipb_g[CK_IRRX];
	assign irtx_clk       = ipb_g[CK_IRTX];
	assign serial3_clk    = ipb_g[CK_SER3];
	assign serial2_clk    = ipb_g[CK_SER2];
	assign serial1_clk    = ipb_g[CK_SER1];
	assign irda_clk       = ipb_g[CK_IRDA];
	assign can_clk        = ipb_g[CK_CAN];
	assign i2c_clk        = ipb_g[CK_I2C];
	assign timer_clk      = ipb_g[CK_TIMER];
	assign gpio_clk       = ipb_g[CK_GPIO];

	// ----------------------------------------------------------------
	// 48 MHz fractional divider and tree
	// ----------------------------------------------------------------
	assign fd_ratio = cdc_ratio(fd_reg[fd_phase_reg*FD_PH_W +: FD_PH_W]);

	always_ff @(posedge aclk) begin
		if (!aresetn || !fd_reg[FRAC_DIVIDER_ENABLE]) begin
			fd_cnt_reg   <= '0;
			fd_phase_reg <= '0;
			fd_out_reg   <= 1'b0;
		end else begin
			fd_out_reg <= (fd_cnt_reg < (fd_ratio >> 1));
			if (fd_cnt_reg >= fd_ratio - 4'h1) begin
				fd_cnt_reg   <= '0;
				fd_phase_reg <= fd_phase_reg + 2'h1;
			end else begin
				fd_cnt_reg <= fd_cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		ext_s1_reg <= ext_48mhz_pin;
		ext_s2_reg <= ext_s1_reg;
		ext_s3_reg <= ext_s2_reg;
		if (ext_s2_reg == ext_s3_reg) begin
			ext_lvl_reg <= ext_s3_reg;
		end
	end

	assign ext_sel = fd_reg[FD_EXT_USB] || fd_reg[FD_EXT_IRDA];

	cdc_clock_gate #(.WIDTH(2)) u_48 (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src_a   (fd_out_reg),
		.src_b   (ext_lvl_reg),
		.sel     (ext_sel),
		.en      ({cke_reg[CK_IRDA], 1'b1}),
		.clk_out (t48_g)
	);

	assign usb_48mhz_clk  = t48_g[0];
	assign irda_48mhz_clk = t48_g[1];

endmodule : cdc_clock_distribution

`default_nettype wire

// File: design/cdc_clock_gate.sv
`timescale 1ns/1ps
`default_nettype none

module cdc_clock_gate
	import cdc_pkg::*;
#(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// Sources
	input  wire logic             src_a,
	input  wire logic             src_b,
	input  wire logic             sel,
	// Gates
	input  wire logic [WIDTH-1:0] en,
	output var  logic [WIDTH-1:0] clk_out
);

	logic             sel_reg;
	logic [WIDTH-1:0] en_reg;
	logic             cur;

	assign cur = sel_reg ? src_b : src_a;

	// Source swaps only while both candidates are low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_reg <= 1'b0;
		end else if (!src_a && !src_b) begin
			sel_reg <= sel;
		end
	end

	// Enables change only while the selected source is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_reg <= '0;
		end else if (!cur) begin
			en_reg <= en;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_out <= '0;
		end else begin
			clk_out <= en_reg & {WIDTH{cur}};
		end
	end

endmodule : cdc_clock_gate

`default_nettype wire

// File: design/cdc_pkg.sv
package cdc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W  = 12;
	localparam int          DATA_W  = 32;
	localparam int          STRB_W  = DATA_W / 8;
	localparam logic [11:0] OFF_ID  = 12'h200;
	localparam logic [11:0] OFF_POR = 12'h204;
	localparam logic [11:0] OFF_BC  = 12'h208;
	localparam logic [11:0] OFF_CFG = 12'h20c;
	localparam logic [11:0] OFF_FD  = 12'h210;
	localparam logic [11:0] OFF_CKE = 12'h214;
	localparam logic [11:0] OFF_OSC = 12'h218;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Identification (field values arbitrary)
	// ----------------------------------------------------------------
	localparam logic [3:0]  ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART    = 16'h00a5;
	localparam logic [10:0] ID_MAKER   = 11'h05a;
	localparam logic [31:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	// ----------------------------------------------------------------
	// Fields (bit 0 = least significant)
	// ----------------------------------------------------------------
	localparam int          POR_W       = 15;
	localparam logic [31:0] POR_MASK    = 32'h0000_7e7f;
	localparam int          POR_XLB     = 5;
	localparam int          POR_PLL0    = 4;

	localparam int          CFG_DDR     = 24;
	localparam int          CFG_XLB     = 16;
	localparam int          CFG_IPB     = 8;
	localparam int          CFG_PCI     = 0;
	localparam logic [31:0] CFG_RW_MASK = 32'h0000_0101;
	localparam logic [31:0] CFG_RESET   = 32'h0000_0101;

	localparam int          FD_EXT_USB  = 25;
	localparam int          FD_EXT_IRDA = 24;
	localparam int          FRAC_DIVIDER_ENABLE       = 16;
	localparam int          FD_PH_W     = 4;
	localparam logic [31:0] FD_RW_MASK  = 32'h0301_ffff;
	localparam logic [31:0] FD_RESET    = 32'h0300_0000;

	localparam logic [31:0] CKE_RW_MASK = 32'h000f_ffff;
	localparam logic [31:0] CKE_RESET   = 32'h000f_ffff;
	localparam int CK_MEM = 19, CK_PCI = 18, CK_LPC = 17, CK_SLT = 16;
	localparam int CK_DMA = 15, CK_ATA = 14, CK_ETH = 13, CK_USB = 12;
	localparam int CK_SPI = 11, CK_PLI = 10, CK_IRRX = 9, CK_IRTX = 8;
	localparam int CK_SER3 = 7, CK_SER2 = 6, CK_SER1 = 5, CK_IRDA = 4;
	localparam int CK_CAN = 3, CK_I2C = 2, CK_TIMER = 1, CK_GPIO = 0;
	localparam int CK_PERIPH_W = 18;

	localparam int          OSC_DIS     = 24;
	localparam logic [31:0] OSC_RW_MASK = 32'h0100_0000;
	localparam logic [31:0] OSC_RESET   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Clock tree slots
	// ----------------------------------------------------------------
	localparam int IPB_PCI = 18, IPB_FREE = 19, IPB_MEM = 20;
	localparam int IPB_TWAKE = 21, IPB_GWAKE = 22, IPB_W = 23;
	localparam int TAP_W = 5;
	localparam logic [2:0] TAP_DBL = 3'h0;
	localparam logic [2:0] TAP_XLB = 3'h1;

	// Phase code to VCO divide ratio, top bit ignored
	function automatic logic [3:0] cdc_ratio(input logic [3:0] code);
		case (code[2:0])
			3'h6:    cdc_ratio = 4'h6;
			3'h7:    cdc_ratio = 4'h7;
			3'h0:    cdc_ratio = 4'h8;
			3'h1:    cdc_ratio = 4'h9;
			3'h2:    cdc_ratio = 4'ha;
			default: cdc_ratio = 4'hb;
		endcase
	endfunction : cdc_ratio

endpackage : cdc_pkg

// File: verification/cdc_clock_distribution_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cdc_clock_distribution_chk
	import cdc_pkg::*;
(
	// Bus
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic [ADDR_W-1:0]	awaddr,
	input wire logic		awvalid,
	input wire logic		awready,
	input wire logic [DATA_W-1:0]	wdata,
	input wire logic [STRB_W-1:0]	wstrb,
	input wire logic		wvalid,
	input wire logic		wready,
	input wire logic		bvalid,
	input wire logic [ADDR_W-1:0]	araddr,
	input wire logic		arvalid,
	input wire logic		arready,
	input wire logic [DATA_W-1:0]	rdata,
	input wire logic		rvalid,
	// Clocks and controls
	input wire logic		osc_disable,
	input wire logic		mem_clk,
	input wire logic		memory_read_clock,
	input wire logic		memory_double_clock,
	input wire logic		memory_double_clock_inv,
	input wire logic		pci_xlb_clk,
	input wire logic		pci_ipb_clk,
	input wire logic		pci_clk,
	input wire logic		lpc_clk,
	input wire logic		can_clk,
	input wire logic		can_clk_inv,
	input wire logic		gpio_wake_clk
);
	logic	osc_w;
	logic	wr_osc;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	assign wr_osc = awvalid && awready && wvalid && wready &&
		awaddr == OFF_OSC && wstrb[3];

	always_ff @(posedge aclk) begin
		if (wr_osc)
			osc_w <= wdata[OSC_DIS];
	end

	AST_ID_READ: assert property (arvalid && arready && araddr == OFF_ID
		|=> rdata == ID_VALUE) else $error("id value wrong");
	AST_RD_LAT: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	AST_WR_LAT: assert property (awvalid && awready && wvalid && wready
		|-> ##2 bvalid) else $error("write answer late");
	AST_OSC_SET: assert property (wr_osc |-> ##[1:3] osc_disable == osc_w)
		else $error("oscillator disable not updated");
	AST_MEM_GATE: assert property (!mem_clk[*8] ##1 !mem_clk[*8] |->
		!$past(memory_read_clock, 8) && !$past(memory_double_clock, 8) &&
		!$past(memory_double_clock_inv, 8))
		else $error("memory clocks not gated");
	AST_PCI_GATE: assert property (!pci_ipb_clk[*8] ##1 !pci_ipb_clk[*8]
		|-> !$past(pci_clk, 8) && !$past(pci_xlb_clk, 8))
		else $error("pci clocks split");
	AST_CAN_INV: assert property (can_clk |-> !can_clk_inv)
		else $error("can clock copies overlap");
	AST_NO_RUNT: assert property (!$stable(lpc_clk) |=> $stable(lpc_clk))
		else $error("runt pulse on gated clock");
	AST_WAKE_FREE: assert property ($fell(gpio_wake_clk)
		|-> ##[1:8] gpio_wake_clk) else $error("wake clock stopped");
endmodule : cdc_clock_distribution_chk

bind cdc_clock_distribution cdc_clock_distribution_chk u_chk (.*);

`default_nettype wire

// File: verification/cdc_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module cdc_periph_model (
	// Clocks
	input  wire logic	aclk,
	input  wire logic	clk_in,
	// Observed edges and period
	output var  int		edges,
	output var  int		period
);
	logic	prev;
	int	cnt;

	initial begin
		prev = 1'b0;
		cnt = 0;
		edges = 0;
		period = 0;
	end

	// Count rising edges of the delivered clock
	always @(posedge aclk) begin
		prev <= clk_in;
		cnt <= cnt + 1;
		if (clk_in && !prev) begin
			edges <= edges + 1;
			period <= cnt + 1;
			cnt <= 0;
		end
	end
endmodule : cdc_periph_model

`default_nettype wire

// File: verification/tb_clock_distribution_config.sv
`timescale 1ns/1ps
`default_nettype none

module tb_clock_distribution_config
	import cdc_pkg::*;
;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic ddr_mode_in, ext_48mhz_pin, awready, wready, bvalid;
	logic arready, rvalid, osc_disable;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [STRB_W-1:0] wstrb;
	logic [POR_W-1:0] strap_pins;
	logic [1:0] bresp, rresp;
	logic mem_clk, memory_read_clock, memory_double_clock, mem_ipb_clk;
	logic memory_double_clock_inv, pci_xlb_clk, pci_ipb_clk, pci_clk;
	logic ipb_free_clk, lpc_clk, slt_clk, dma_clk, ata_clk, eth_clk;
	logic usb_clk, spi_clk, pli_clk, irrx_clk, irtx_clk, serial3_clk;
	logic serial2_clk, serial1_clk, irda_clk, can_clk, can_clk_inv;
	logic i2c_clk, timer_clk, timer_wake_clk, gpio_clk, gpio_wake_clk;
	logic usb_48mhz_clk, irda_48mhz_clk;
	int mismatches, cmp_count, e0, e1, ec, i;
	int e_usb, p_usb, e_lpc, p_lpc, e_ir, p_ir, e_pci, p_pci;
	int e_tw, p_tw, e_mi, p_mi, e_rd, p_rd, e2, e3;
	int ratio[8] = '{8, 9, 10, 11, 11, 11, 6, 7};

	cdc_clock_distribution dut (.*);
	cdc_periph_model m_usb (.aclk(aclk), .clk_in(usb_48mhz_clk),
		.edges(e_usb), .period(p_usb));
	cdc_periph_model m_lpc (.aclk(aclk), .clk_in(lpc_clk),
		.edges(e_lpc), .period(p_lpc));
	cdc_periph_model m_ir (.aclk(aclk), .clk_in(irda_48mhz_clk),
		.edges(e_ir), .period(p_ir));
	cdc_periph_model m_pci (.aclk(aclk), .clk_in(pci_clk),
		.edges(e_pci), .period(p_pci));
	cdc_periph_model m_tw (.aclk(aclk), .clk_in(timer_wake_clk),
		.edges(e_tw), .period(p_tw));
	cdc_periph_model m_mi (.aclk(aclk), .clk_in(mem_ipb_clk),
		.edges(e_mi), .period(p_mi));
	cdc_periph_model m_rd (.aclk(aclk), .clk_in(memory_read_clock),
		.edges(e_rd), .period(p_rd));

	// ------------------------------------------------
	// Stimulus helpers
	// ------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// External 48 MHz stand-in, period 40 cycles
	always @(posedge aclk) begin
		ec <= (ec == 19) ? 0 : ec + 1;
		if (ec == 19)
			ext_48mhz_pin <= ~ext_48mhz_pin;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask : idle

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				bready <= 1'b0;
				chk({30'h0, bresp}, {30'h0, er});
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				rready <= 1'b0;
				chk(rdata, ed);
				chk({30'h0, rresp}, {30'h0, er});
				break;
			end
		end
	endtask : rd

	task automatic report_and_stop;
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end

	// ------------------------------------------------
	// Tests
	// ------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, ext_48mhz_pin, ec} = '0;
		strap_pins = 15'h7f5f;
		ddr_mode_in = 1'b1;
		idle(2);
		aresetn <= 1'b1;
		rd(OFF_ID, ID_VALUE, RESP_OKAY);
		wr(OFF_ID, 32'h0, RESP_OKAY);
		rd(OFF_ID, ID_VALUE, RESP_OKAY);
		rd(OFF_POR, 32'h0000_7e5f, RESP_OKAY);
		wr(OFF_BC, 32'h5a5a_c3c3, RESP_OKAY);
		idle(40);
		chk(p_lpc, 8);
		chk(p_pci, 16);
		wr(OFF_CFG, 32'h0000_0001, RESP_OKAY);
		rd(OFF_CFG, 32'h0101_0001, RESP_OKAY);
		idle(40);
		chk(p_lpc, 4);
		chk(p_pci, 8);
		chk(p_usb, 40);
		chk(p_rd, 2);
		ddr_mode_in <= 1'b0;
		rd(OFF_CFG, 32'h0001_0001, RESP_OKAY);
		idle(20);
		chk(p_rd, 4);
		ddr_mode_in <= 1'b1;
		wr(OFF_CKE, 32'h0, RESP_OKAY);
		idle(60);
		{e0, e1, e2, e3} = {e_lpc, e_ir, e_tw, e_mi};
		idle(60);
		chk(e_lpc, e0);
		chk(e_ir, e1);
		chk(e_tw - e2, 15);
		chk(e_mi - e3, 15);
		wr(OFF_CKE, 32'hffff_ffff, RESP_OKAY);
		rd(OFF_CKE, 32'h000f_ffff, RESP_OKAY);
		idle(40);
		chk(p_lpc, 4);
		for (i = 0; i < 2; i++) begin
			wr(OFF_FD, 32'h0100_0000 << i, RESP_OKAY);
			idle(90);
			chk(p_usb, 40);
		end
		for (i = 0; i < 8; i++) begin
			wr(OFF_FD, 32'h0001_0000 | {4{i[0], i[2:0]}}, RESP_OKAY);
			idle(50);
			chk(p_usb, ratio[i]);
		end
		wr(OFF_FD, 32'h0, RESP_OKAY);
		idle(20);
		e0 = e_usb;
		idle(40);
		chk(e_usb, e0);
		rd(12'h21c, 32'h0, RESP_SLVERR);
		wr(12'h21c, 32'h0, RESP_SLVERR);
		wr(OFF_OSC, 32'h0100_0000, RESP_OKAY);
		idle(2);
		chk({31'h0, osc_disable}, 32'h1);
		aresetn <= 1'b0;
		idle(2);
		aresetn <= 1'b1;
		rd(OFF_BC, 32'h5a5a_c3c3, RESP_OKAY);
		rd(OFF_OSC, OSC_RESET, RESP_OKAY);
		rd(OFF_CFG, 32'h0101_0101, RESP_OKAY);
		rd(OFF_FD, FD_RESET, RESP_OKAY);
		rd(OFF_CKE, CKE_RESET, RESP_OKAY);
		report_and_stop();
	end
endmodule : tb_clock_distribution_config

`default_nettype wire
